// *** mmdt_defs.vh ***
// Constants for the multi-mode digital timer: register map, fields, resets, timing.
// Assumes inclusion by the timer, the checker and the testbench; definitions only.
`ifndef MMDT_DEFS_VH
`define MMDT_DEFS_VH
// ----------------------------------------
// Time base
// ----------------------------------------
`define MMDT_CLK_HZ 50000000
`define MMDT_TICK_NS 1000000
`define MMDT_CLK_NS 20
`define MMDT_TICK_CYC (`MMDT_TICK_NS / `MMDT_CLK_NS)
`define MMDT_TIME_W 27
`define MMDT_TIME_MAX 27'h5f5dd18
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define MMDT_REG_CTRL 4'h0
`define MMDT_REG_TIME 4'h1
`define MMDT_REG_ELAPSED 4'h2
`define MMDT_REG_REMAIN 4'h3
`define MMDT_REG_STATUS 4'h4
// ----------------------------------------
// Control fields
// ----------------------------------------
`define MMDT_CTRL_FUNC_LSB 0
`define MMDT_CTRL_FUNC_MSB 1
`define MMDT_CTRL_RUN_POL 4
`define MMDT_CTRL_OUT_POL 5
`define MMDT_FUNC_OFF 2'h0
`define MMDT_FUNC_PULSE 2'h1
`define MMDT_FUNC_HOLDOFF 2'h2
`define MMDT_FUNC_COUNTDOWN 2'h3
`define MMDT_CTRL_RST 6'h30
`define MMDT_TIME_RST 27'h0000000
`endif

// *** mmdt_timer.v ***
// Multi-mode digital timer: pulse, hold-off and countdown with Avalon-MM registers.
// Assumes one 50 MHz clock; run input is asynchronous and is synchronised here.
//
// Summary of operation
// RQ1 - Pulse mode: active trigger edge drives output active, elapsed starts at zero.
// RQ2 - Pulse mode: output stays active for full duration regardless of input.
// RQ3 - Pulse mode: a new trigger edge while running restarts, lengthening the pulse.
// RQ4 - Pulse mode: at duration, output goes inactive and elapsed clears.
// RQ5 - Pulse mode: elapsed shows time since trigger, zero when idle.
// RQ6 - Duration and elapsed range 0 to 99999.000 in millisecond units.
// RQ7 - Trigger polarity high picks rising edge, low picks falling edge.
// RQ8 - Output polarity high means pin high when active, low means pin low.
// RQ9 - Elapsed values clear to zero at reset.
// RQ10 - Hold-off: elapsed counts while input active, output active and frozen at duration.
// RQ11 - Hold-off: input inactive drives output inactive and clears elapsed at once.
// RQ12 - Hold-off: output only after input continuously active for whole duration.
// RQ13 - Hold-off: trigger polarity gives on-delay or off-delay.
// RQ14 - Countdown: output active while remaining time above zero, running or paused.
// RQ15 - Countdown: input active decrements remaining and increments elapsed together.
// RQ16 - Countdown: load with input active starts counting immediately.
// RQ17 - Countdown: load with input inactive activates output but waits for input.
// RQ18 - Countdown: input inactive freezes both counts, output stays active.
// RQ19 - Countdown: at zero remaining, output inactive, elapsed clears, load not kept.
// RQ20 - Countdown: trigger polarity is a level, high counts while input high.
// RQ21 - Countdown: remaining clears at reset, output inactive.
// RQ22 - Off setting stops timing and holds output at inactive level.
// RQ23 - Counts advance one unit per one millisecond tick derived from clock.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "mmdt_defs.vh"

module mmdt_timer (
   // Clock, reset, enable
   input wire clk,
   input wire rst,
   input wire clk_en,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Timer pins
   input wire run_in,
   output reg timer_out
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [26:0] sat_time;
      input [31:0] v;
      begin
         if (v[31:27] != 5'h00 || v[26:0] > `MMDT_TIME_MAX) begin
            sat_time = `MMDT_TIME_MAX;
         end else begin
            sat_time = v[26:0];
         end
      end
   endfunction

   // Elapsed has met the programmed duration
   function time_up;
      input [26:0] e;
      input [26:0] t;
      begin
         time_up = e >= t;
      end
   endfunction

   // One tick forward, saturating at the range top
   function [26:0] time_inc;
      input [26:0] x;
      begin
         if (x >= `MMDT_TIME_MAX) begin
            time_inc = `MMDT_TIME_MAX;
         end else begin
            time_inc = x + 27'h0000001;
         end
      end
   endfunction

   // Time value is zero
   function time_zero;
      input [26:0] x;
      begin
         time_zero = x == `MMDT_TIME_RST;
      end
   endfunction

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   reg [26:0] elapsed_d;
   reg [26:0] remain_d;
   reg running_d;
   reg act_d;
   reg [5:0] ctrl_q;
   reg [26:0] time_q;
   reg [26:0] elapsed_q;
   reg [26:0] remain_q;
   reg running_q;
   reg act_q;
   reg load_q;
   reg [26:0] load_val_q;
   reg [16:0] tick_cnt_q;
   reg tick_q;
   reg run_s1_q;
   reg run_s2_q;
   reg run_prev_q;
   reg ack_q;
   reg [1:0] mode_prev_q;

   wire [1:0] func = ctrl_q[`MMDT_CTRL_FUNC_MSB:`MMDT_CTRL_FUNC_LSB];
   wire run_pol = ctrl_q[`MMDT_CTRL_RUN_POL];
   wire out_pol = ctrl_q[`MMDT_CTRL_OUT_POL];
   wire run_act = run_s2_q ~^ run_pol; // RQ20
   wire run_act_prev = run_prev_q ~^ run_pol;
   wire trig_edge = run_act & ~run_act_prev; // RQ7 RQ13
   wire bus_req = avs_read | avs_write;
   wire mode_chg = func != mode_prev_q;

   // ----------------------------------------
   // Avalon slave, one wait cycle per access
   // ----------------------------------------
   // Waitrequest held until the registered acknowledge so reads see settled state
   assign avs_waitrequest = bus_req & ~ack_q;

   always @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         ctrl_q <= `MMDT_CTRL_RST;
         time_q <= `MMDT_TIME_RST;
         load_q <= 1'b0;
         load_val_q <= `MMDT_TIME_RST;
         avs_readdata <= 32'h00000000;
      end else if (clk_en) begin
         ack_q <= bus_req & ~ack_q;
         load_q <= 1'b0;
         // Read data loaded on the wait cycle so it stands when waitrequest drops
         if (bus_req & ~ack_q) begin
            avs_readdata <= 32'h00000000;
            if (avs_read) begin
               case (avs_address)
                  `MMDT_REG_CTRL: avs_readdata <= {26'h0000000, ctrl_q};
                  `MMDT_REG_TIME: avs_readdata <= {5'h00, time_q};
                  `MMDT_REG_ELAPSED: avs_readdata <= {5'h00, elapsed_q};
                  `MMDT_REG_REMAIN: avs_readdata <= {5'h00, remain_q};
                  `MMDT_REG_STATUS: avs_readdata <= {30'h00000000, running_q, act_q};
                  default: avs_readdata <= 32'h00000000;
               endcase
            end
         end
         // Writes land only at the edge where waitrequest is low
         if (avs_write & ack_q) begin
            begin
               case (avs_address)
                  `MMDT_REG_CTRL: ctrl_q <= avs_writedata[5:0];
                  `MMDT_REG_TIME: time_q <= sat_time(avs_writedata); // RQ6
                  `MMDT_REG_REMAIN: begin
                     load_q <= 1'b1;
                     load_val_q <= sat_time(avs_writedata); // RQ6
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         run_s1_q <= 1'b0;
         run_s2_q <= 1'b0;
         run_prev_q <= 1'b0;
      end else if (clk_en) begin
         run_s1_q <= run_in;
         run_s2_q <= run_s1_q;
         run_prev_q <= run_s2_q;
      end
   end

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   // One millisecond tick; resolution is the lowest printed time digit
   always @(posedge clk) begin
      if (rst) begin
         tick_cnt_q <= 17'h00000;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         if (tick_cnt_q == `MMDT_TICK_CYC - 1) begin // RQ23
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
            tick_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Timing engine, next state
   // ----------------------------------------
   always @* begin
      elapsed_d = elapsed_q;
      remain_d = remain_q;
      running_d = running_q;
      act_d = act_q;
      if (mode_chg) begin
         // Switching modes clears elapsed, running and active; the remaining count is kept
         elapsed_d = `MMDT_TIME_RST;
         running_d = 1'b0;
         act_d = 1'b0;
      end else begin
         case (func)
            `MMDT_FUNC_PULSE: begin
               if (trig_edge) begin
                  // Restart from zero so the pulse runs a full duration again
                  running_d = 1'b1; // RQ1 RQ3
                  act_d = 1'b1; // RQ1
                  elapsed_d = `MMDT_TIME_RST; // RQ1 RQ3
               end else if (running_q) begin
                  if (time_up(elapsed_q, time_q)) begin
                     running_d = 1'b0; // RQ4
                     act_d = 1'b0; // RQ4
                     elapsed_d = `MMDT_TIME_RST; // RQ4 RQ5
                  end else if (tick_q) begin
                     elapsed_d = time_inc(elapsed_q); // RQ2 RQ5
                  end
               end else begin
                  act_d = 1'b0;
                  elapsed_d = `MMDT_TIME_RST; // RQ5
               end
            end
            `MMDT_FUNC_HOLDOFF: begin
               if (!run_act) begin
                  running_d = 1'b0; // RQ11
                  act_d = 1'b0; // RQ11
                  elapsed_d = `MMDT_TIME_RST; // RQ11 RQ12
               end else if (time_up(elapsed_q, time_q)) begin
                  running_d = 1'b0;
                  act_d = 1'b1; // RQ10
               end else begin
                  running_d = 1'b1;
                  act_d = 1'b0; // RQ12
                  if (tick_q) begin
                     elapsed_d = time_inc(elapsed_q); // RQ10
                  end
               end
            end
            `MMDT_FUNC_COUNTDOWN: begin
               // A load restarts the count from the new value with fresh elapsed
               if (load_q) begin
                  remain_d = load_val_q; // RQ16 RQ17
                  elapsed_d = `MMDT_TIME_RST;
                  act_d = !time_zero(load_val_q); // RQ17
                  running_d = run_act & !time_zero(load_val_q); // RQ16
               end else if (time_zero(remain_q)) begin
                  act_d = 1'b0; // RQ19
                  running_d = 1'b0;
                  elapsed_d = `MMDT_TIME_RST; // RQ19
               end else begin
                  act_d = 1'b1; // RQ14 RQ18
                  running_d = run_act; // RQ18
                  if (run_act && tick_q) begin
                     remain_d = remain_q - 27'h0000001; // RQ15
                     if (remain_q == 27'h0000001) begin
                        elapsed_d = `MMDT_TIME_RST; // RQ19
                     end else begin
                        elapsed_d = time_inc(elapsed_q); // RQ15
                     end
                  end
               end
            end
            default: begin
               running_d = 1'b0; // RQ22
               act_d = 1'b0; // RQ22
               elapsed_d = `MMDT_TIME_RST;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Timing engine, state
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         elapsed_q <= `MMDT_TIME_RST; // RQ9
         remain_q <= `MMDT_TIME_RST; // RQ21
         running_q <= 1'b0;
         act_q <= 1'b0;
         mode_prev_q <= `MMDT_FUNC_OFF;
      end else if (clk_en) begin
         mode_prev_q <= func;
         elapsed_q <= elapsed_d;
         remain_q <= remain_d;
         running_q <= running_d;
         act_q <= act_d;
      end
   end

   // ----------------------------------------
   // Output pin
   // ----------------------------------------
   // Registered, so the pin reflects state one cycle after it changes
   always @(posedge clk) begin
      if (rst) begin
         timer_out <= 1'b0;
      end else if (clk_en) begin
         timer_out <= act_q ~^ out_pol; // RQ8 RQ22
      end
   end

endmodule // mmdt_timer

// *** mmdt_run_src.sv ***
// Run source model: registered logic output that feeds the trigger pin.
// Assumes the timer clock; the line has no pull, it is always driven.
`timescale 1ns/1ps
module mmdt_run_src (
   // Clock
   input wire clk,
   // Level request and pin
   input wire lvl,
   output reg run_in
);
   // Registered like a real logic block, so edges never land mid-cycle
   initial run_in = 1'b0;
   always @(posedge clk) begin
      run_in <= lvl;
   end
endmodule // mmdt_run_src

// *** mmdt_timer_asserts.sv ***
// Checker on the timer ports: bus handshake and output levels.
// Assumes clk_en high while the shadow of the control word matters.
`timescale 1ns/1ps
`include "mmdt_defs.vh"
module mmdt_chk (
   // Clock and reset
   input wire clk,
   input wire rst,
   input wire clk_en,
   // Bus
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   // Pins
   input wire run_in,
   input wire timer_out
);
   reg [5:0] ctl_q;
   reg [3:0] quiet_q;
   wire req = avs_read | avs_write;
   wire done = avs_write & ~avs_waitrequest & clk_en;
   wire ok = quiet_q == 4'hf;
   wire rp = ctl_q[`MMDT_CTRL_RUN_POL];
   wire op = ctl_q[`MMDT_CTRL_OUT_POL];
   wire [1:0] fn = ctl_q[1:0];
   // Quiet counts cycles since any write, so pipeline latency has settled
   always @(posedge clk) begin
      if (rst) begin
         ctl_q <= `MMDT_CTRL_RST;
         quiet_q <= 4'h0;
      end else if (done) begin
         if (avs_address == `MMDT_REG_CTRL) ctl_q <= avs_writedata[5:0];
         quiet_q <= 4'h0;
      end else if (!ok && clk_en) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest)
      else $error("waitrequest low on a new request");
   AST_WAIT_ONE: assert property (req && avs_waitrequest && clk_en |=> !avs_waitrequest)
      else $error("more than one wait cycle");
   AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest high with no request");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest &&
      avs_address > `MMDT_REG_STATUS |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RESET_OUT: assert property ($fell(rst) |-> !timer_out)
      else $error("output active after reset");
   AST_OFF_LEVEL: assert property (ok && fn == `MMDT_FUNC_OFF |-> timer_out == ~op)
      else $error("off mode output not inactive");
   AST_HOLD_DROP: assert property ((ok && fn == `MMDT_FUNC_HOLDOFF && run_in != rp)[*8]
      |-> timer_out == ~op)
      else $error("hold-off output active with input inactive");
   AST_CD_PAUSE: assert property ((ok && fn == `MMDT_FUNC_COUNTDOWN && run_in != rp)[*8]
      |-> $stable(timer_out))
      else $error("countdown output moved while paused");
endmodule // mmdt_chk
bind mmdt_timer mmdt_chk i_mmdt_chk (.clk(clk), .rst(rst), .clk_en(clk_en),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .run_in(run_in), .timer_out(timer_out));

// *** mmdt_timer_tb_top.sv ***
// Testbench for the timer: bus tasks, pin stimulus, one task per scenario.
// Assumes the checker is bound and the run source model drives the pin.
`timescale 1ns/1ps
`include "mmdt_defs.vh"
module mmdt_timer_tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg clk_en = 1'b1;
   reg [3:0] adr = 4'h0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wdat = 32'h0;
   reg lvl = 1'b0;
   reg [31:0] v;
   wire [31:0] rdat;
   wire wait_r;
   wire run_in;
   wire timer_out;
   integer err_total = 0;
   integer compares = 0;
   integer cyc = 0;
   integer p;
   mmdt_run_src i_mmdt_run_src (.clk(clk), .lvl(lvl), .run_in(run_in));
   mmdt_timer i_mmdt_timer (.clk(clk), .rst(rst), .clk_en(clk_en), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
      .avs_waitrequest(wait_r), .run_in(run_in), .timer_out(timer_out));
   initial forever #10 clk = ~clk;
   // Ceiling covers one 1 ms countdown tick plus the short scenarios
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total = err_total + 1;
         close_out();
      end
   end
   task close_out;
      begin
         if (err_total == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk_word(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Pin sampled at the falling edge, where it has settled
   task pin_is(input e);
      begin
         @(negedge clk);
         chk_word({31'h0, timer_out}, {31'h0, e});
      end
   endtask
   task bus(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         adr <= a;
         wr <= w;
         rd <= ~w;
         wdat <= d;
         @(posedge clk);
         while (wait_r !== 1'b0) @(posedge clk);
         v = rdat;
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task run_to(input x, input e);
      begin
         @(posedge clk);
         lvl <= x;
         repeat (24) @(posedge clk);
         pin_is(e);
      end
   endtask
   task t_reset;
      begin
         bus(1'b0, `MMDT_REG_CTRL, 32'h0); chk_word(v, 32'h30);
         bus(1'b0, `MMDT_REG_ELAPSED, 32'h0); chk_word(v, 32'h0);
         bus(1'b0, `MMDT_REG_REMAIN, 32'h0); chk_word(v, 32'h0);
         bus(1'b1, 4'h9, 32'hffffffff);
         bus(1'b0, 4'h9, 32'h0); chk_word(v, 32'h0);
         pin_is(1'b0);
      end
   endtask
   task t_off;
      begin
         bus(1'b1, `MMDT_REG_CTRL, 32'h10);
         run_to(1'b1, 1'b1);
         run_to(1'b0, 1'b1);
      end
   endtask
   task t_hold;
      begin
         bus(1'b1, `MMDT_REG_TIME, 32'h0);
         for (p = 0; p < 2; p = p + 1) begin
            bus(1'b1, `MMDT_REG_CTRL, p ? 32'h32 : 32'h22);
            run_to(p == 1, 1'b1);
            run_to(p == 0, 1'b0);
         end
         bus(1'b1, `MMDT_REG_TIME, 32'h3e8);
         bus(1'b1, `MMDT_REG_CTRL, 32'h32);
         run_to(1'b1, 1'b0);
         run_to(1'b0, 1'b0);
         bus(1'b0, `MMDT_REG_ELAPSED, 32'h0); chk_word(v, 32'h0);
      end
   endtask
   task t_pulse;
      begin
         bus(1'b1, `MMDT_REG_CTRL, 32'h21);
         run_to(1'b1, 1'b0);
         run_to(1'b0, 1'b1);
         run_to(1'b1, 1'b1);
         bus(1'b1, `MMDT_REG_TIME, 32'h0);
         repeat (5) @(posedge clk);
         pin_is(1'b0);
         bus(1'b0, `MMDT_REG_ELAPSED, 32'h0); chk_word(v, 32'h0);
      end
   endtask
   task t_cd;
      begin
         bus(1'b1, `MMDT_REG_CTRL, 32'h33);
         run_to(1'b0, 1'b0);
         bus(1'b1, `MMDT_REG_REMAIN, 32'h1);
         repeat (100) @(posedge clk);
         pin_is(1'b1);
         bus(1'b0, `MMDT_REG_REMAIN, 32'h0); chk_word(v, 32'h1);
         @(posedge clk);
         lvl <= 1'b1;
         p = 0;
         while (timer_out !== 1'b0 && p < 60000) begin
            @(negedge clk);
            p = p + 1;
         end
         pin_is(1'b0);
         bus(1'b0, `MMDT_REG_ELAPSED, 32'h0); chk_word(v, 32'h0);
         bus(1'b0, `MMDT_REG_REMAIN, 32'h0); chk_word(v, 32'h0);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_off;
      t_hold;
      t_pulse;
      t_cd;
      close_out();
   end
endmodule // mmdt_timer_tb_top
